/* File: common/pmt_pkg.sv */
package pmt_pkg;
    localparam int PMT_WORD_W = 16;
    localparam int PMT_ADDR_W = 13;
    localparam int PMT_DEPTH_SMALL = 4096;
    localparam int PMT_DEPTH_LARGE = 8192;
    localparam logic [12:0] PMT_RESET_VECTOR = 13'h0000;
    localparam logic [7:0] PMT_THB_RESET = 8'h00;
    localparam logic [7:0] PMT_DATA_RESET = 8'h00;
    localparam logic [4:0] PMT_LAST_PAGE_SMALL = 5'h0f;
    localparam logic [4:0] PMT_LAST_PAGE_LARGE = 5'h1f;
    localparam int PMT_TABLE_CYCLES = 2;
    localparam int PMT_DREG_W = 9;
    localparam int PMT_SER_LEN = 24;
    typedef enum logic [1:0] {
        PMT_OP_NONE,
        PMT_OP_PTR,
        PMT_OP_LAST
    } pmt_op_t;
endpackage : pmt_pkg

/* File: hdl/pmt_prog_link.sv */
`timescale 1ns/10ps
`default_nettype none
module pmt_prog_link #(
    parameter int ADDR_W = 13,
    parameter int WORD_W = 16
) (
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    input wire logic prog_mode_i,
    input wire logic prog_serial_clock_line_i,
    input wire logic prog_serial_data_line_i,
    input wire logic [WORD_W-1:0] rd_word_i,
    output logic prog_serial_data_line_o,
    output logic prog_serial_data_line_oe_o,
    output logic [ADDR_W-1:0] addr_o,
    output logic [WORD_W-1:0] wdata_o,
    output logic wr_o,
    output logic rd_o
);
    import pmt_pkg::*;
    // Frame: 2-bit command (01 write, 10 read), 13-bit address, 16-bit data (msb first)
    logic [2:0] ck_sync_ff, nxt_ck_sync;
    logic [1:0] da_sync_ff, nxt_da_sync;
    logic [5:0] cnt_ff, nxt_cnt;
    logic [30:0] sh_ff, nxt_sh;
    logic [WORD_W-1:0] out_ff, nxt_out;
    logic oe_ff, nxt_oe;
    logic wr_ff, nxt_wr;
    logic rd_ff, nxt_rd;
    logic rise;

    always_comb begin
        nxt_ck_sync = {ck_sync_ff[1:0], prog_serial_clock_line_i};
        nxt_da_sync = {da_sync_ff[0], prog_serial_data_line_i};
        rise = ck_sync_ff[1] & ~ck_sync_ff[2];
        nxt_cnt = cnt_ff;
        nxt_sh = sh_ff;
        nxt_out = out_ff;
        nxt_oe = oe_ff;
        nxt_wr = 1'b0;
        nxt_rd = 1'b0;
        if (!prog_mode_i) begin
            nxt_cnt = 6'h00;
            nxt_oe = 1'b0;
        end else if (rd_ff) begin
            nxt_out = rd_word_i;
            nxt_oe = 1'b1;
        end else if (rise) begin
            if (oe_ff) begin
                nxt_out = {out_ff[WORD_W-2:0], 1'b0};
                nxt_cnt = cnt_ff + 6'h01;
                if (cnt_ff == 6'h1f) begin
                    nxt_oe = 1'b0;
                    nxt_cnt = 6'h00;
                end
            end else begin
                nxt_sh = {sh_ff[29:0], da_sync_ff[1]};
                nxt_cnt = cnt_ff + 6'h01;
                if (cnt_ff == 6'h0e && sh_ff[13:12] == 2'b10) begin
                    nxt_rd = 1'b1;
                    nxt_cnt = 6'h10;
                end else if (cnt_ff == 6'h1e) begin
                    nxt_wr = sh_ff[29:28] == 2'b01;
                    nxt_cnt = 6'h00;
                end
            end
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ck_sync_ff <= 3'h0;
            da_sync_ff <= 2'h0;
            cnt_ff <= 6'h00;
            sh_ff <= 31'h0;
            out_ff <= '0;
            oe_ff <= 1'b0;
            wr_ff <= 1'b0;
            rd_ff <= 1'b0;
        end else begin
            ck_sync_ff <= nxt_ck_sync;
            da_sync_ff <= nxt_da_sync;
            cnt_ff <= nxt_cnt;
            sh_ff <= nxt_sh;
            out_ff <= nxt_out;
            oe_ff <= nxt_oe;
            wr_ff <= nxt_wr;
            rd_ff <= nxt_rd;
        end
    end

    assign prog_serial_data_line_o = out_ff[WORD_W-1];
    assign prog_serial_data_line_oe_o = oe_ff;
    assign addr_o = wr_ff ? sh_ff[28:16] : sh_ff[12:0];
    assign wdata_o = sh_ff[15:0];
    assign wr_o = wr_ff;
    assign rd_o = rd_ff;
endmodule : pmt_prog_link
`default_nettype wire

/* File: hdl/pmt_table_read.sv */
`timescale 1ns/10ps
`default_nettype none
// Behaviour
// - Program store of 16-bit words, 4K or 8K deep, addressed by the PC
// - After reset the program counter starts fetching from word zero
// - Table address is formed from both pointer bytes, or from the low byte and LAST_PAGE for the last-page form
// - Low byte of the table word goes to the destination data register
// - High byte of the table word goes to the table high-byte holder
// - Table high-byte holder is readable by software, and writable except in the cycle a table read loads it
// - Every table instruction takes two instruction cycles
// - Short forms reach sector 0; extended forms reach any sector
// - Programming moves data serially on one data line with external clock
module pmt_table_read #(
    parameter int DEPTH = pmt_pkg::PMT_DEPTH_SMALL,
    parameter logic [4:0] LAST_PAGE = pmt_pkg::PMT_LAST_PAGE_SMALL
) (
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    input wire logic [pmt_pkg::PMT_ADDR_W-1:0] pc_i,
    input wire logic pc_load_i,
    input wire logic fetch_i,
    input wire logic [7:0] tbl_ptr_lo_i,
    input wire logic [7:0] tbl_ptr_hi_i,
    input wire logic tbl_rd_i,
    input wire logic tbl_last_i,
    input wire logic tbl_ext_i,
    input wire logic [pmt_pkg::PMT_DREG_W-1:0] tbl_dest_i,
    input wire logic thb_wr_i,
    input wire logic [7:0] thb_wdata_i,
    input wire logic prog_mode_i,
    input wire logic prog_serial_clock_line_i,
    input wire logic prog_serial_data_line_i,
    output logic [pmt_pkg::PMT_ADDR_W-1:0] pc_o,
    output logic [pmt_pkg::PMT_WORD_W-1:0] instr_o,
    output logic instr_valid_o,
    output logic tbl_busy_o,
    output logic dmem_we_o,
    output logic [pmt_pkg::PMT_DREG_W-1:0] dmem_addr_o,
    output logic [7:0] dmem_wdata_o,
    output logic [7:0] table_high_byte_holder_o,
    output logic prog_serial_data_line_o,
    output logic prog_serial_data_line_oe_o
);
    import pmt_pkg::*;
    localparam int AW = $clog2(DEPTH);
    typedef enum logic [1:0] {PMT_PH_IDLE, PMT_PH_READ, PMT_PH_DONE} pmt_phase_t;

    logic [PMT_WORD_W-1:0] mem [DEPTH];
    logic [PMT_ADDR_W-1:0] pc_ff, nxt_pc;
    logic [PMT_WORD_W-1:0] instr_ff, nxt_instr;
    logic ivalid_ff, nxt_ivalid;
    pmt_phase_t phase_ff, nxt_phase;
    pmt_op_t op_ff, nxt_op;
    logic busy_ff, nxt_busy;
    logic [PMT_ADDR_W-1:0] taddr_ff, nxt_taddr;
    logic [PMT_DREG_W-1:0] dest_ff, nxt_dest;
    logic [PMT_WORD_W-1:0] tword_ff;
    logic dwe_ff, nxt_dwe;
    logic [7:0] dwd_ff, nxt_dwd;
    logic [7:0] thb_ff, nxt_thb;
    logic [PMT_ADDR_W-1:0] p_addr;
    logic [PMT_WORD_W-1:0] p_wdata;
    logic p_wr, p_rd;
    logic [PMT_WORD_W-1:0] p_rword;

    function automatic logic [PMT_ADDR_W-1:0] tbl_addr(input logic last, input logic [7:0] lo,
                                                       input logic [7:0] hi);
        if (last)
            tbl_addr = {LAST_PAGE, lo};
        else
            tbl_addr = {hi[4:0], lo};
    endfunction : tbl_addr

    pmt_prog_link #(.ADDR_W(PMT_ADDR_W), .WORD_W(PMT_WORD_W)) u_link (
        .core_clk_i(core_clk_i),
        .rst_n_i(rst_n_i),
        .prog_mode_i(prog_mode_i),
        .prog_serial_clock_line_i(prog_serial_clock_line_i),
        .prog_serial_data_line_i(prog_serial_data_line_i),
        .rd_word_i(p_rword),
        .prog_serial_data_line_o(prog_serial_data_line_o),
        .prog_serial_data_line_oe_o(prog_serial_data_line_oe_o),
        .addr_o(p_addr),
        .wdata_o(p_wdata),
        .wr_o(p_wr),
        .rd_o(p_rd)
    );

    always_ff @(posedge core_clk_i) begin
        if (p_wr)
            mem[p_addr[AW-1:0]] <= p_wdata;
        tword_ff <= mem[taddr_ff[AW-1:0]];
    end

    // Read word must be ready at the edge where the link loads it
    assign p_rword = p_rd ? mem[p_addr[AW-1:0]] : '0;

    always_comb begin
        nxt_pc = pc_ff;
        nxt_instr = instr_ff;
        nxt_ivalid = 1'b0;
        nxt_phase = PMT_PH_IDLE;
        nxt_op = op_ff;
        nxt_taddr = taddr_ff;
        nxt_dest = dest_ff;
        nxt_dwe = 1'b0;
        nxt_dwd = dwd_ff;
        nxt_thb = thb_ff;
        if (thb_wr_i)
            nxt_thb = thb_wdata_i;
        case (phase_ff)
            PMT_PH_IDLE: begin
                if (tbl_rd_i && !prog_mode_i) begin
                    nxt_op = tbl_last_i ? PMT_OP_LAST : PMT_OP_PTR;
                    nxt_taddr = tbl_addr(tbl_last_i, tbl_ptr_lo_i, tbl_ptr_hi_i);
                    nxt_dest = tbl_ext_i ? tbl_dest_i : {1'b0, tbl_dest_i[7:0]};
                    nxt_phase = PMT_PH_READ;
                end else if (pc_load_i) begin
                    nxt_pc = pc_i;
                end else if (fetch_i && !prog_mode_i) begin
                    nxt_instr = mem[pc_ff[AW-1:0]];
                    nxt_ivalid = 1'b1;
                    nxt_pc = pc_ff + 13'h0001;
                end
            end
            PMT_PH_READ: begin
                nxt_phase = PMT_PH_DONE;
            end
            PMT_PH_DONE: begin
                nxt_dwe = 1'b1;
                nxt_dwd = tword_ff[7:0];
                nxt_thb = tword_ff[15:8];
                nxt_op = PMT_OP_NONE;
            end
            default: begin
                nxt_phase = PMT_PH_IDLE;
            end
        endcase
        nxt_busy = nxt_op != PMT_OP_NONE;
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pc_ff <= PMT_RESET_VECTOR;
            instr_ff <= '0;
            ivalid_ff <= 1'b0;
            phase_ff <= PMT_PH_IDLE;
            op_ff <= PMT_OP_NONE;
            busy_ff <= 1'b0;
            taddr_ff <= '0;
            dest_ff <= '0;
            dwe_ff <= 1'b0;
            dwd_ff <= PMT_DATA_RESET;
            thb_ff <= PMT_THB_RESET;
        end else begin
            pc_ff <= nxt_pc;
            instr_ff <= nxt_instr;
            ivalid_ff <= nxt_ivalid;
            phase_ff <= nxt_phase;
            op_ff <= nxt_op;
            busy_ff <= nxt_busy;
            taddr_ff <= nxt_taddr;
            dest_ff <= nxt_dest;
            dwe_ff <= nxt_dwe;
            dwd_ff <= nxt_dwd;
            thb_ff <= nxt_thb;
        end
    end

    assign pc_o = pc_ff;
    assign instr_o = instr_ff;
    assign instr_valid_o = ivalid_ff;
    assign tbl_busy_o = busy_ff;
    assign dmem_we_o = dwe_ff;
    assign dmem_addr_o = dest_ff;
    assign dmem_wdata_o = dwd_ff;
    assign table_high_byte_holder_o = thb_ff;

    sequence s_tbl_start;
        phase_ff == PMT_PH_IDLE && tbl_rd_i && !prog_mode_i;
    endsequence
    sequence s_busy_two;
        tbl_busy_o ##1 tbl_busy_o;
    endsequence
    a_table_two_cycles: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        s_tbl_start |=> !dmem_we_o ##1 !dmem_we_o ##1 dmem_we_o)
        else $error("Table read did not finish in two cycles");
    a_reset_pc_zero: assert property (@(posedge core_clk_i)
        $rose(rst_n_i) |-> pc_o == PMT_RESET_VECTOR)
        else $error("PC not zero after reset");
    a_addr_both_ptr: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        (s_tbl_start and !tbl_last_i) |=>
            taddr_ff == {$past(tbl_ptr_hi_i[4:0]), $past(tbl_ptr_lo_i)})
        else $error("Table address not from both pointers");
    a_last_page: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        (s_tbl_start and tbl_last_i) |=> taddr_ff == {LAST_PAGE, $past(tbl_ptr_lo_i)})
        else $error("Last page address wrong");
    a_low_to_dest: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        dmem_we_o |-> dmem_wdata_o == $past(tword_ff[7:0]))
        else $error("Low byte not written");
    a_high_holder: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        dmem_we_o |-> table_high_byte_holder_o == $past(tword_ff[15:8]))
        else $error("High byte not held");
    a_holder_write: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        thb_wr_i && phase_ff != PMT_PH_DONE |=> table_high_byte_holder_o == $past(thb_wdata_i))
        else $error("Holder write lost");
    a_short_sector0: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        (s_tbl_start and !tbl_ext_i) |=> dmem_addr_o[8] == 1'b0)
        else $error("Short form left sector 0");
    a_busy_window: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        s_tbl_start |=> s_busy_two ##1 !tbl_busy_o)
        else $error("Busy window not two cycles");
    a_fetch_advance: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        phase_ff == PMT_PH_IDLE && fetch_i && !tbl_rd_i && !pc_load_i && !prog_mode_i |=>
            instr_valid_o && pc_o == $past(pc_o) + 13'h0001)
        else $error("Fetch did not advance the PC");
    a_link_release: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        !prog_mode_i |=> !prog_serial_data_line_oe_o)
        else $error("Data line driven outside programming");
endmodule : pmt_table_read
`default_nettype wire

/* File: sim/pmt_prog_model.sv */
`timescale 1ns/10ps
`default_nettype none
module pmt_prog_model (
    input wire logic core_clk_i,
    input wire logic data_line_i,
    output logic clk_line_o,
    output logic data_line_o,
    output logic data_oe_o
);
    initial begin
        clk_line_o = 1'b0;
        data_line_o = 1'b0;
        data_oe_o = 1'b0;
    end

    // One bit: data set while the clock is low, sampled back just before it rises
    task automatic shift(input logic b, input logic oe, output logic s);
        repeat (4) @(posedge core_clk_i);
        data_line_o <= b;
        data_oe_o <= oe;
        repeat (4) @(posedge core_clk_i);
        s = data_line_i;
        clk_line_o <= 1'b1;
        repeat (4) @(posedge core_clk_i);
        clk_line_o <= 1'b0;
    endtask : shift

    // Command, address and data msb first; the line is let go while the device answers
    task automatic frame(input logic [1:0] cmd, input logic [12:0] addr,
                         input logic [15:0] wd, output logic [15:0] rd);
        logic [30:0] sh;
        logic s;
        sh = {cmd, addr, wd};
        for (int i = 30; i >= 0; i--) begin
            shift(sh[i], !(cmd == 2'b10 && i < 16), s);
            rd = {rd[14:0], s};
        end
        data_oe_o <= 1'b0;
    endtask : frame
endmodule : pmt_prog_model
`default_nettype wire

/* File: sim/tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin n_mismatch++; \
    $display("ERROR %0t: got %h expected %h", $time, g, e); end end
module tb_top;
    import pmt_pkg::*;
    logic core_clk_i, rst_n_i = 1'b0, pc_load_i = 1'b0, fetch_i = 1'b0, tbl_rd_i = 1'b0;
    logic tbl_last_i = 1'b0, tbl_ext_i = 1'b0, thb_wr_i = 1'b0, prog_mode_i = 1'b0;
    logic [12:0] pc_i = 13'h0000, pc_o;
    logic [7:0] lo_i = 8'h00, hi_i = 8'h00, thb_wdata_i = 8'h00, dwdata, holder;
    logic [8:0] dest_i = 9'h000, daddr;
    logic [15:0] instr_o, rd;
    logic ivalid, busy, we, dut_d, dut_oe, ser_clk, mdl_d, mdl_oe, idle_lvl = 1'b0;
    logic [12:0] mem_a [5] = '{13'h0000, 13'h0006, 13'h0f05, 13'h0f06, 13'h0fff};
    logic [15:0] mem_d [5] = '{16'h1234, 16'h7e81, 16'h3cc3, 16'ha55a, 16'hbeef};
    wire logic ser_dat;
    int n_mismatch = 0, tests_run = 0, cycles = 0;
    // Released line shows a changing level, never a held one
    assign ser_dat = dut_oe ? dut_d : (mdl_oe ? mdl_d : idle_lvl);

    pmt_table_read #(.DEPTH(PMT_DEPTH_SMALL), .LAST_PAGE(PMT_LAST_PAGE_SMALL)) pmt_table_read_i (
        .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .pc_i(pc_i), .pc_load_i(pc_load_i),
        .fetch_i(fetch_i), .tbl_ptr_lo_i(lo_i), .tbl_ptr_hi_i(hi_i), .tbl_rd_i(tbl_rd_i),
        .tbl_last_i(tbl_last_i), .tbl_ext_i(tbl_ext_i), .tbl_dest_i(dest_i),
        .thb_wr_i(thb_wr_i), .thb_wdata_i(thb_wdata_i), .prog_mode_i(prog_mode_i),
        .prog_serial_clock_line_i(ser_clk), .prog_serial_data_line_i(ser_dat),
        .pc_o(pc_o), .instr_o(instr_o), .instr_valid_o(ivalid), .tbl_busy_o(busy),
        .dmem_we_o(we), .dmem_addr_o(daddr), .dmem_wdata_o(dwdata),
        .table_high_byte_holder_o(holder), .prog_serial_data_line_o(dut_d),
        .prog_serial_data_line_oe_o(dut_oe));

    pmt_prog_model pmt_prog_model_i (.core_clk_i(core_clk_i), .data_line_i(ser_dat),
        .clk_line_o(ser_clk), .data_line_o(mdl_d), .data_oe_o(mdl_oe));

    initial begin
        core_clk_i = 1'b0;
        forever #5 core_clk_i = ~core_clk_i;
    end

    always @(posedge core_clk_i) begin
        idle_lvl <= ~idle_lvl;
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_mismatch++;
            complete_run();
        end
    end

    task automatic complete_run();
        $display("Comparisons %0d, mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : complete_run

    task automatic do_fetch(input logic [15:0] exp);
        int seen = 0;
        @(posedge core_clk_i);
        fetch_i <= 1'b1;
        repeat (4) begin
            @(posedge core_clk_i);
            fetch_i <= 1'b0;
            #1;
            if (ivalid === 1'b1) begin
                seen++;
                `CHK(instr_o, exp)
            end
        end
        `CHK(seen, 1)
    endtask : do_fetch

    // Second request lands while busy and must be ignored
    task automatic do_table(input logic last, input logic ext, input logic [7:0] hi,
                            input logic [7:0] lo, input logic [8:0] dest,
                            input logic [8:0] exp_addr, input logic [15:0] exp_word);
        int we_at = 0;
        int n_we = 0;
        @(posedge core_clk_i);
        tbl_rd_i <= 1'b1;
        tbl_last_i <= last;
        tbl_ext_i <= ext;
        hi_i <= hi;
        lo_i <= lo;
        dest_i <= dest;
        for (int i = 0; i < 7; i++) begin
            @(posedge core_clk_i);
            tbl_rd_i <= (i == 1);
            #1;
            if (i == 1) `CHK(busy, 1'b1)
            if (i == 2) `CHK(busy, 1'b0)
            if (we === 1'b1) begin
                n_we++;
                we_at = i;
                `CHK(daddr, exp_addr)
                `CHK(dwdata, exp_word[7:0])
                `CHK(holder, exp_word[15:8])
            end
        end
        `CHK(we_at, 2)
        `CHK(n_we, 1)
    endtask : do_table

    task automatic t_holder();
        @(posedge core_clk_i);
        thb_wr_i <= 1'b1;
        thb_wdata_i <= 8'h96;
        @(posedge core_clk_i);
        thb_wr_i <= 1'b0;
        @(posedge core_clk_i);
        #1;
        `CHK(holder, 8'h96)
    endtask : t_holder

    initial begin
        repeat (4) @(posedge core_clk_i);
        rst_n_i <= 1'b1;
        @(posedge core_clk_i);
        #1;
        `CHK(pc_o, PMT_RESET_VECTOR)
        `CHK(holder, PMT_THB_RESET)
        prog_mode_i <= 1'b1;
        foreach (mem_a[k]) pmt_prog_model_i.frame(2'b01, mem_a[k], mem_d[k], rd);
        pmt_prog_model_i.frame(2'b10, 13'h0f06, 16'h0000, rd);
        `CHK(rd, 16'ha55a)
        repeat (4) @(posedge core_clk_i);
        #1;
        `CHK(dut_oe, 1'b0)
        prog_mode_i <= 1'b0;
        do_fetch(16'h1234);
        `CHK(pc_o, 13'h0001)
        @(posedge core_clk_i);
        pc_i <= 13'h0fff;
        pc_load_i <= 1'b1;
        @(posedge core_clk_i);
        pc_load_i <= 1'b0;
        @(posedge core_clk_i);
        #1;
        `CHK(pc_o, 13'h0fff)
        do_fetch(16'hbeef);
        do_table(1'b0, 1'b1, 8'h0f, 8'h06, 9'h105, 9'h105, 16'ha55a);
        do_table(1'b0, 1'b0, 8'h00, 8'h06, 9'h105, 9'h005, 16'h7e81);
        do_table(1'b1, 1'b0, 8'h00, 8'h05, 9'h021, 9'h021, 16'h3cc3);
        do_table(1'b1, 1'b1, 8'h07, 8'h06, 9'h1ff, 9'h1ff, 16'ha55a);
        t_holder();
        @(posedge core_clk_i);
        rst_n_i <= 1'b0;
        repeat (2) @(posedge core_clk_i);
        rst_n_i <= 1'b1;
        @(posedge core_clk_i);
        #1;
        `CHK(pc_o, PMT_RESET_VECTOR)
        `CHK(holder, PMT_THB_RESET)
        complete_run();
    end
endmodule : tb_top
`default_nettype wire
